// File: include/lpnp_consts.svh
// Offsets, field positions and reset values of the partner next page register
`ifndef LPNP_CONSTS_SVH
`define LPNP_CONSTS_SVH
`define LPNP_CTRL_ADDR       8'h6E
`define LPNP_OFFS_ADDR       8'h6F
`define LPNP_DATA_ADDR       8'hA0
`define LPNP_FUNC_EEE        3'h1
`define LPNP_PORT_MIN        4'h3
`define LPNP_PORT_MAX        4'h4
`define LPNP_OFFS_HI         8'h10
`define LPNP_OFFS_LO         8'h11
`define LPNP_OFFS_STAT       8'h12
`define LPNP_BIT_MORE        15
`define LPNP_BIT_ACK         14
`define LPNP_BIT_MSG         13
`define LPNP_BIT_COMPLY      12
`define LPNP_BIT_TOGGLE      11
`define LPNP_PAGE_RESET      16'h0000
`define LPNP_BYTE_RESET      8'h00
`define LPNP_FLAG_RESET      4'h0
`define LPNP_NPORTS          2
`endif

// File: include/lpnp_pkg.sv
// Types of the partner next page register block
package lpnp_pkg;
    typedef struct packed {
        logic        more_pages_flag;
        logic        ack_flag;
        logic        message_page_flag;
        logic        will_comply_flag;
        logic        toggle_flag;
        logic [10:0] code_field;
    } lpnp_page_t;
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } lpnp_bus_t;
endpackage

// File: rtl/lpnp_page_store.sv
// Per-port store of the last received next page
`timescale 1ns/1ps
`default_nettype none
`include "lpnp_consts.svh"
module lpnp_page_store
    import lpnp_pkg::*;
(
    // Clock and reset
    input  wire logic       ref_clk_in,
    input  wire logic       arst_n_in,
    // Page capture
    input  wire logic       page_valid_in,
    input  var  lpnp_page_t page_in,
    input  wire logic       clear_flag_in,
    // Stored state
    output var  lpnp_page_t page_out,
    output logic            received_out
);
    lpnp_page_t page_reg;
    lpnp_page_t page_next;
    logic       rcv_reg;
    logic       rcv_next;

    always_comb begin
        page_next = page_reg;
        rcv_next  = rcv_reg;
        if (clear_flag_in) begin
            rcv_next = 1'b0;
        end
        if (page_valid_in) begin
            page_next = page_in;   // (RULE11)
            rcv_next  = 1'b1;      // (RULE12)
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            page_reg <= `LPNP_PAGE_RESET; // (RULE10)
            rcv_reg  <= 1'b0;
        end else begin
            page_reg <= page_next;
            rcv_reg  <= rcv_next;
        end
    end

    assign page_out     = page_reg;
    assign received_out = rcv_reg;
endmodule
`default_nettype wire

// File: rtl/lpnp_next_page_rx.sv
// Partner next page receive register with indirect byte access
//
// Function
// (RULE1) Control byte selects group and port
// (RULE2) Offset byte selects byte at data register
// (RULE3) Upper byte 0x10, lower byte 0x11
// (RULE4) Bit 15 reports more pages follow
// (RULE5) Bit 14 reports partner acknowledge
// (RULE6) Bit 13 message versus unformatted page
// (RULE7) Bit 12 reports partner will comply
// (RULE8) Bit 11 toggle alternates per codeword
// (RULE9) First toggle inverts base codeword bit
// (RULE10) Code in 10:0, read-only, resets zero
// (RULE11) Whole page captured in one cycle
// (RULE12) Page received flag, cleared on read
`timescale 1ns/1ps
`default_nettype none
`include "lpnp_consts.svh"
module lpnp_next_page_rx
    import lpnp_pkg::*;
(
    // Clock and reset
    input  wire logic              ref_clk_in,
    input  wire logic              arst_n_in,
    // Register access, one-cycle strobes
    input  var  lpnp_bus_t         bus_in,
    output logic [7:0]             rdata_out,
    // Pages from the negotiation logic, index 0 is port 3
    input  wire logic [1:0]        page_valid_in,
    input  var  lpnp_page_t [1:0]  page_in,
    // Decoded fields of the selected port
    output logic                   more_pages_flag_out,
    output logic                   message_page_flag_out,
    output logic                   will_comply_flag_out,
    output logic                   page_received_out
);
    // ------------------------------------------------------------
    // Indirect select registers
    // ------------------------------------------------------------
    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic [7:0] offs_reg;
    logic [7:0] offs_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    lpnp_page_t [1:0] page_q;
    logic [1:0]       rcv_q;
    logic [1:0]       clr_flag;
    lpnp_page_t [1:0] page_fut;
    logic [1:0]       rcv_fut;

    // Group and port check shared by read and flag clearing
    function automatic logic sel_ok(input logic [7:0] c);
        sel_ok = (c[7:5] == `LPNP_FUNC_EEE) && (c[3:0] >= `LPNP_PORT_MIN)
                 && (c[3:0] <= `LPNP_PORT_MAX); // (RULE1)
    endfunction

    function automatic logic sel_idx(input logic [7:0] c);
        sel_idx = (c[3:0] == `LPNP_PORT_MAX);
    endfunction

    // Status offset, shared by the read mux and the flag clear
    function automatic logic is_stat(input logic [7:0] o);
        is_stat = (o == `LPNP_OFFS_STAT);
    endfunction

    function automatic logic data_rd(input lpnp_bus_t b);
        data_rd = b.rd && (b.addr == `LPNP_DATA_ADDR);
    endfunction

    // Byte of a stored page picked by the offset, zero when unmapped
    function automatic logic [7:0] page_byte(input lpnp_page_t p, input logic [7:0] o);
        page_byte = `LPNP_BYTE_RESET;
        if (o == `LPNP_OFFS_HI) begin
            page_byte = {p.more_pages_flag,    // (RULE4)
                         p.ack_flag,           // (RULE5)
                         p.message_page_flag,  // (RULE6)
                         p.will_comply_flag,   // (RULE7)
                         p.toggle_flag,        // (RULE8)
                         p.code_field[10:8]};  // (RULE10)
        end else if (o == `LPNP_OFFS_LO) begin
            page_byte = p.code_field[7:0];     // (RULE10)
        end
    endfunction

    logic       ok;
    logic       idx;
    lpnp_page_t cur;
    assign ok  = sel_ok(ctrl_reg);
    assign idx = sel_idx(ctrl_reg);
    assign cur = page_q[idx];

    // ------------------------------------------------------------
    // Per-port page storage
    // ------------------------------------------------------------
    // Set wins over the read clear inside the store
    genvar g;
    generate
        for (g = 0; g < `LPNP_NPORTS; g = g + 1) begin : g_port
            assign clr_flag[g] = data_rd(bus_in) && ok && (idx == 1'(g))
                                 && is_stat(offs_reg); // (RULE12)
            lpnp_page_store u_store (
                .ref_clk_in    (ref_clk_in),
                .arst_n_in     (arst_n_in),
                .page_valid_in (page_valid_in[g]),
                .page_in       (page_in[g]),
                .clear_flag_in (clr_flag[g]),
                .page_out      (page_q[g]),
                .received_out  (rcv_q[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Stored page next state
    // ------------------------------------------------------------
    // Mirrors the store so the flag outputs can be registered in step
    genvar h;
    generate
        for (h = 0; h < `LPNP_NPORTS; h = h + 1) begin : g_fut
            assign page_fut[h] = page_valid_in[h] ? page_in[h] : page_q[h]; // (RULE11)
            assign rcv_fut[h]  = page_valid_in[h] | (rcv_q[h] & ~clr_flag[h]); // (RULE12)
        end
    endgenerate

    // ------------------------------------------------------------
    // Select registers
    // ------------------------------------------------------------
    always_comb begin
        ctrl_next = ctrl_reg;
        offs_next = offs_reg;
        if (bus_in.wr && bus_in.addr == `LPNP_CTRL_ADDR) begin
            ctrl_next = bus_in.wdata; // (RULE1)
        end
        if (bus_in.wr && bus_in.addr == `LPNP_OFFS_ADDR) begin
            offs_next = bus_in.wdata; // (RULE2)
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ctrl_reg <= `LPNP_BYTE_RESET;
            offs_reg <= `LPNP_BYTE_RESET;
        end else begin
            ctrl_reg <= ctrl_next;
            offs_reg <= offs_next;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    // Read data holds between reads, so software may sample it late
    always_comb begin
        rdata_next = rdata_reg;
        if (bus_in.rd) begin
            unique case (bus_in.addr)
                `LPNP_CTRL_ADDR: rdata_next = ctrl_reg;
                `LPNP_OFFS_ADDR: rdata_next = offs_reg;
                `LPNP_DATA_ADDR: begin
                    // Writes to the data byte are ignored, the page is read-only
                    if (!ok) begin
                        rdata_next = `LPNP_BYTE_RESET; // (RULE1)
                    end else if (is_stat(offs_reg)) begin
                        rdata_next = {7'h00, rcv_q[idx]}; // (RULE12)
                    end else begin
                        rdata_next = page_byte(cur, offs_reg); // (RULE3)
                    end
                end
                default: rdata_next = `LPNP_BYTE_RESET; // (RULE2)
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rdata_reg <= `LPNP_BYTE_RESET;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // ------------------------------------------------------------
    // Registered flag outputs
    // ------------------------------------------------------------
    // Next flags come from the next page and the next select, so the
    // outputs leave flip-flops yet move in the cycle the page is stored
    logic       idx_fut;
    lpnp_page_t cur_fut;
    logic [3:0] flag_reg;
    logic [3:0] flag_next;
    assign idx_fut = sel_idx(ctrl_next);
    assign cur_fut = page_fut[idx_fut];

    always_comb begin
        flag_next[3] = cur_fut[`LPNP_BIT_MORE];   // (RULE4)
        flag_next[2] = cur_fut[`LPNP_BIT_MSG];    // (RULE6)
        flag_next[1] = cur_fut[`LPNP_BIT_COMPLY]; // (RULE7)
        flag_next[0] = rcv_fut[idx_fut];          // (RULE12)
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            flag_reg <= `LPNP_FLAG_RESET;
        end else begin
            flag_reg <= flag_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rdata_out             = rdata_reg;
    assign more_pages_flag_out   = flag_reg[3];
    assign message_page_flag_out = flag_reg[2];
    assign will_comply_flag_out  = flag_reg[1];
    assign page_received_out     = flag_reg[0];
    // Toggle reported as received, alternation stays the partner's duty (RULE9)
endmodule
`default_nettype wire

// File: testbench/lpnp_chk.sv
// Assertions on the next page register ports
`timescale 1ns/1ps
`default_nettype none
module lpnp_chk
    import lpnp_pkg::*;
(
    // Clock, reset, access
    input wire logic             ref_clk_in,
    input wire logic             arst_n_in,
    input var  lpnp_bus_t        bus_in,
    input wire logic [7:0]       rdata_out,
    // Pages and flags
    input wire logic [1:0]       page_valid_in,
    input var  lpnp_page_t [1:0] page_in,
    input wire logic             more_pages_flag_out,
    input wire logic             message_page_flag_out,
    input wire logic             will_comply_flag_out,
    input wire logic             page_received_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!arst_n_in);
    logic [7:0] ctl_reg;
    logic [7:0] offs_reg;
    logic       ok;
    logic       ix;
    logic       rda;
    logic [2:0] fl;
    assign ok = ctl_reg[7:5] == 3'h1 && ctl_reg[3:0] inside {4'h3, 4'h4};
    assign ix = ~ctl_reg[0];
    assign rda = bus_in.rd && bus_in.addr == 8'hA0;
    assign fl = {more_pages_flag_out, message_page_flag_out, will_comply_flag_out};
    // Shadow of the selection, so checks know the port
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            {ctl_reg, offs_reg} <= 16'h0000;
        end else if (bus_in.wr) begin
            if (bus_in.addr == 8'h6E) ctl_reg <= bus_in.wdata;
            if (bus_in.addr == 8'h6F) offs_reg <= bus_in.wdata;
        end
    end
    a_unmapped_zero: assert property (bus_in.rd && !(bus_in.addr inside {8'h6E, 8'h6F, 8'hA0})
        |=> rdata_out == 8'h00) else $error("unmapped read");
    a_bad_select: assert property (rda && !ok |=> rdata_out == 8'h00)
        else $error("bad select read");
    a_rdata_holds: assert property (!bus_in.rd |=> $stable(rdata_out))
        else $error("read data moved");
    a_upper_byte: assert property (rda && ok && offs_reg == 8'h10 && page_valid_in == 2'h0
        |=> {rdata_out[7], rdata_out[5:4]} == fl) else $error("upper byte");
    a_flags_stable: assert property (!bus_in.wr && page_valid_in == 2'h0 |=> $stable(fl))
        else $error("flags moved");
    a_page_capture: assert property (ok && page_valid_in[ix] && !bus_in.wr
        |=> ##[0:1] page_received_out) else $error("page not flagged");
    a_recv_latched: assert property (page_received_out && !bus_in.rd && !bus_in.wr
        |=> page_received_out) else $error("flag lost");
    a_stat_clear: assert property (rda && ok && offs_reg == 8'h12 && page_valid_in == 2'h0
        |=> rdata_out[0] == $past(page_received_out) && !page_received_out) else $error("clear");
    c_data_read: cover property (rda && ok);
    c_both_pages: cover property (page_valid_in == 2'h3);
    c_flag_clear: cover property (page_received_out ##1 !page_received_out);
endmodule
bind lpnp_next_page_rx lpnp_chk lpnp_chk_inst (.*);
`default_nettype wire

// File: testbench/lpnp_partner.sv
// Model of the remote partner sending next pages
`timescale 1ns/1ps
`default_nettype none
module lpnp_partner
    import lpnp_pkg::*;
(
    // Clock, reset, base codeword toggle
    input  wire logic             clk_in,
    input  wire logic             arst_n_in,
    input  wire logic             base_tog_in,
    // Page request and pages out
    input  wire logic [1:0]       send_in,
    input  var  lpnp_page_t       pg_in,
    output logic [1:0]            valid_out,
    output var  lpnp_page_t [1:0] page_out
);
    logic [1:0] tog_reg;
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            tog_reg <= {2{base_tog_in}};
            valid_out <= 2'h0;
            page_out <= '0;
        end else begin
            valid_out <= send_in;
            for (int i = 0; i < 2; i++) begin
                if (send_in[i]) begin
                    page_out[i] <= pg_in;
                    page_out[i].ack_flag <= 1'b1;
                    page_out[i].toggle_flag <= ~tog_reg[i];
                    tog_reg[i] <= ~tog_reg[i];
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: testbench/test_lp_next_page_receive_reg.sv
// Bench of the next page register
`timescale 1ns/1ps
`default_nettype none
module test_lp_next_page_receive_reg;
    import lpnp_pkg::*;
    logic             clk = 1'b0;
    logic             arst_n = 1'b0;
    lpnp_bus_t        bus = '0;
    logic [1:0]       snd = 2'h0;
    lpnp_page_t       pg = '0;
    logic [1:0]       vld;
    lpnp_page_t [1:0] pgs;
    logic [7:0]       rdat;
    logic [7:0]       q;
    logic [7:0]       h;
    wire  [3:0]       fl;
    int               n_mismatch = 0;
    int               samples_checked = 0;
    always #5 clk = ~clk;
    lpnp_partner lpnp_partner_inst (.clk_in(clk), .arst_n_in(arst_n), .base_tog_in(1'b1),
        .send_in(snd), .pg_in(pg), .valid_out(vld), .page_out(pgs));
    lpnp_next_page_rx lpnp_next_page_rx_inst (.ref_clk_in(clk), .arst_n_in(arst_n),
        .bus_in(bus), .rdata_out(rdat), .page_valid_in(vld), .page_in(pgs),
        .more_pages_flag_out(fl[3]), .message_page_flag_out(fl[2]),
        .will_comply_flag_out(fl[1]), .page_received_out(fl[0]));
    task results;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask
    task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{w, ~w, a, d};
        @(posedge clk);
        bus <= '0;
    endtask
    task rdb(input logic [7:0] c, input logic [7:0] o);
        acc(1'b1, 8'h6E, c);
        acc(1'b1, 8'h6F, o);
        acc(1'b0, 8'hA0, 8'h00);
        @(negedge clk);
        q = rdat;
    endtask
    task rpg(input logic [7:0] c, input logic [15:0] e);
        rdb(c, 8'h10);
        h = q;
        rdb(c, 8'h11);
        chk({h, q}, e);
    endtask
    task snd_pg(input logic [1:0] s, input lpnp_page_t p);
        @(posedge clk);
        snd <= s;
        pg <= p;
        @(posedge clk);
        snd <= 2'h0;
        repeat (3) @(posedge clk);
    endtask
    initial begin
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        rpg(8'h23, 16'h0000);
        snd_pg(2'h3, {1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 11'h5A5});
        rpg(8'h23, 16'hE5A5);
        chk(fl, 4'hD);
        snd_pg(2'h2, {1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 11'h7FF});
        rpg(8'h24, 16'h5FFF);
        chk(fl, 4'h3);
        rdb(8'h23, 8'h12);
        chk(q, 8'h01);
        rdb(8'h23, 8'h12);
        chk(q, 8'h00);
        acc(1'b1, 8'hA0, 8'hFF);
        rpg(8'h23, 16'hE5A5);
        acc(1'b0, 8'h55, 8'h00);
        @(negedge clk);
        chk(rdat, 8'h00);
        rdb(8'h43, 8'h10);
        chk(q, 8'h00);
        rdb(8'h25, 8'h10);
        chk(q, 8'h00);
        @(posedge clk);
        arst_n <= 1'b0;
        @(posedge clk);
        arst_n <= 1'b1;
        rpg(8'h24, 16'h0000);
        results;
    end
endmodule
`default_nettype wire
